// file: include/dco_pkg.sv
`default_nettype none
package dco_pkg;
    // Error bands in per-mille of the target period.
    localparam logic [9:0] COARSE_BAND_PM = 10'h096; // 150 = 15%
    localparam logic [9:0] FINE_BAND_PM   = 10'h032; // 50 = 5%
    // Step sizes on the stage field.
    localparam logic [7:0] COARSE_STEP    = 8'h20;   // stage bit 5
    localparam logic [7:0] MEDIUM_STEP    = 8'h08;   // about 1.61..2.94%
    localparam logic [7:0] FINE_STEP      = 8'h01;   // about 0.202..0.368%
    localparam int         BASE_PER_STEP  = 4;
    localparam int         MEDIUM_MAX     = 8;
    localparam int         FINE_MAX       = 24;
    localparam logic [3:0] DIV_MAX        = 4'h9;
    localparam logic [3:0] DIV_RESET      = 4'h0;
    localparam logic [7:0] STAGE_RESET    = 8'h80;
    localparam int         RING_MIN       = 17;
    typedef enum logic [1:0] {REG_COARSE, REG_MEDIUM, REG_FINE, REG_DONE}
        regime_t;
endpackage
`default_nettype wire

// file: rtl/dco_ring_map.sv
`timescale 1ns/1ps
`default_nettype none
module dco_ring_map (
    input  wire logic [3:0] div_code,
    input  wire logic [2:0] stage_hi,
    output logic      [3:0] div_eff,
    output logic      [4:0] ring_len
);
    always_comb begin
        div_eff = (div_code > dco_pkg::DIV_MAX) ? dco_pkg::DIV_MAX
                                               : div_code;
        ring_len = 5'(dco_pkg::RING_MIN) + {1'b0, stage_hi, 1'b0};
    end
endmodule // dco_ring_map
`default_nettype wire

// file: rtl/dco_loop_filter.sv
// Operation
// - Medium steps between fifteen and five percent.
// - Medium regime ends within eight steps.
// - Each correction spans four base-clock periods.
// - Set stable flag when within five percent, or once the medium steps run out.
// - Minimum steps once within five percent.
// - Fine regime ends within 24 steps.
// - Software writes fields while generator disabled.
// - Re-enable starts from last written fields.
// - Divider saturates at nine; higher codes act nine.
// - Coarse steps above fifteen percent error.
// - Upper stage bits select ring 17..31.
`timescale 1ns/1ps
`default_nettype none
module dco_loop_filter #(
    // Counts of the regimes; the defaults are the documented figures.
    parameter int MEDIUM_STEPS   = dco_pkg::MEDIUM_MAX,
    parameter int FINE_STEPS     = dco_pkg::FINE_MAX,
    parameter int TICKS_PER_STEP = dco_pkg::BASE_PER_STEP
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       base_tick,
    input  wire logic       internal_gen_enable,
    input  wire logic       mult_change,
    input  wire logic       err_valid,
    input  wire logic       err_too_slow,
    input  wire logic [9:0] err_pm,
    input  wire logic       sw_div_wr,
    input  wire logic [3:0] sw_div_data,
    input  wire logic       sw_stage_wr,
    input  wire logic [7:0] sw_stage_data,
    output logic      [3:0] dco_divider_field,
    output logic      [7:0] dco_stage_field,
    output logic      [3:0] div_effective,
    output logic      [4:0] ring_length,
    output logic      [1:0] regime,
    output logic            clock_stable_flag
);
    typedef struct packed {
        logic [3:0]          en_s;
        logic [3:0]          div;
        logic [7:0]          stage;
        logic [3:0]          div_eff;
        logic [4:0]          ring;
        logic [1:0]          tick_cnt;
        logic [4:0]          step_cnt;
        dco_pkg::regime_t    reg_st;
        logic                stable;
    } state_t;

    state_t     s_q;
    state_t     s_d;
    logic [3:0] map_div;
    logic [4:0] map_ring;
    logic [8:0] sum;
    logic [7:0] step;
    logic       tick_last;
    logic       band_coarse;
    logic       band_medium;
    logic       medium_left;
    logic       fine_spent;
    logic       in_settled;

    // The step counter is five bits wide and the tick counter two, so
    // larger counts could not be told apart and are refused here.
    if (MEDIUM_STEPS < 1 || MEDIUM_STEPS > 31) begin : g_bad_medium
        $error("MEDIUM_STEPS must lie in 1..31");
    end
    if (FINE_STEPS < 1 || FINE_STEPS > 31) begin : g_bad_fine
        $error("FINE_STEPS must lie in 1..31");
    end
    if (TICKS_PER_STEP < 1 || TICKS_PER_STEP > 4) begin : g_bad_ticks
        $error("TICKS_PER_STEP must lie in 1..4");
    end

    // Band decode is kept apart from the state update for readability.
    assign tick_last   = (s_q.tick_cnt == 2'(TICKS_PER_STEP - 1));
    assign band_coarse = (err_pm > dco_pkg::COARSE_BAND_PM);
    assign band_medium = (err_pm > dco_pkg::FINE_BAND_PM);
    assign medium_left = (s_q.step_cnt < 5'(MEDIUM_STEPS));
    assign fine_spent  = (s_q.step_cnt >= 5'(FINE_STEPS - 1));
    assign in_settled  = (s_q.reg_st == dco_pkg::REG_FINE ||
                          s_q.reg_st == dco_pkg::REG_DONE);

    dco_ring_map u_map (
        .div_code (s_q.div),
        .stage_hi (s_q.stage[7:5]),
        .div_eff  (map_div),
        .ring_len (map_ring)
    );

    // Next-state logic. Only the synchronised enable, never the raw pin, is
    // looked at, so a write strobe near an enable edge is either taken
    // whole or ignored whole.
    always_comb begin
        s_d = s_q;
        sum = 9'h000;
        step = dco_pkg::FINE_STEP;
        s_d.en_s = {s_q.en_s[2:0], internal_gen_enable};
        s_d.div_eff = map_div;
        s_d.ring = map_ring;
        if (!s_q.en_s[3]) begin
            // Disabled: only software moves the operating point.
            if (sw_div_wr) begin
                s_d.div = sw_div_data;
            end
            if (sw_stage_wr) begin
                s_d.stage = sw_stage_data;
            end
            // The tick counter restarts so that the first correction after
            // enable spans a full step.
            s_d.tick_cnt = 2'h0;
            s_d.step_cnt = 5'h00;
            s_d.reg_st = dco_pkg::REG_COARSE;
            s_d.stable = 1'b0;
        end else if (mult_change) begin
            // A new multiplier invalidates the settled state but keeps the
            // operating point as the start of the next search.
            s_d.reg_st = dco_pkg::REG_COARSE;
            s_d.step_cnt = 5'h00;
            s_d.stable = 1'b0;
        end else if (base_tick) begin
            // Fields held from disable are the start point.
            // Software strobes are not looked at here.
            s_d.tick_cnt = tick_last ? 2'h0 : s_q.tick_cnt + 2'h1;
            if (tick_last && err_valid) begin
                if (band_coarse) begin
                    step = dco_pkg::COARSE_STEP;
                    s_d.reg_st = dco_pkg::REG_COARSE;
                    s_d.step_cnt = 5'h00;
                end else if (band_medium && medium_left) begin
                    step = dco_pkg::MEDIUM_STEP;
                    s_d.reg_st = dco_pkg::REG_MEDIUM;
                    s_d.step_cnt = s_q.step_cnt + 5'h01;
                end else begin
                    // Bound the medium regime: eight steps then fine.
                    // The flag rises on entry to the fine regime, so a loop
                    // that ran out of medium steps still reports usable.
                    if (!in_settled) begin
                        s_d.step_cnt = 5'h00;
                    end
                    s_d.stable = 1'b1;
                    step = dco_pkg::FINE_STEP;
                    s_d.reg_st = dco_pkg::REG_FINE;
                    if (s_q.reg_st == dco_pkg::REG_DONE ||
                        (s_q.reg_st == dco_pkg::REG_FINE && fine_spent)) begin
                        s_d.reg_st = dco_pkg::REG_DONE;
                        step = 8'h00;
                    end else if (s_q.reg_st == dco_pkg::REG_FINE) begin
                        s_d.step_cnt = s_q.step_cnt + 5'h01;
                    end
                end
                // Stage carry or borrow moves the divider.
                // At the ends of the divider range the stage saturates
                // instead of wrapping, so the period never jumps back.
                if (err_too_slow) begin
                    sum = {1'b0, s_q.stage} - {1'b0, step};
                    if (sum[8]) begin
                        if (s_q.div != 4'h0) begin
                            s_d.div = s_q.div - 4'h1;
                            s_d.stage = sum[7:0];
                        end else begin
                            s_d.stage = 8'h00;
                        end
                    end else begin
                        s_d.stage = sum[7:0];
                    end
                end else begin
                    sum = {1'b0, s_q.stage} + {1'b0, step};
                    if (sum[8]) begin
                        if (s_q.div < dco_pkg::DIV_MAX) begin
                            s_d.div = s_q.div + 4'h1;
                            s_d.stage = sum[7:0];
                        end else begin
                            s_d.stage = 8'hFF;
                        end
                    end else begin
                        s_d.stage = sum[7:0];
                    end
                end
            end
        end
    end

    // One register bank holds the whole state; the mid-range stage code
    // after reset lets the first corrections move either way.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{en_s:     4'h0,
                     div:      dco_pkg::DIV_RESET,
                     stage:    dco_pkg::STAGE_RESET,
                     div_eff:  4'h0,
                     ring:     5'h00,
                     tick_cnt: 2'h0,
                     step_cnt: 5'h00,
                     reg_st:   dco_pkg::REG_COARSE,
                     stable:   1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // The enable passes two synchronising stages before any logic sees it,
    // and two more let a write strobe settle first; the cost is a
    // four-cycle lag on every enable change.
    // Every output is a register field; the ring map is re-registered so
    // that the oscillator never sees a combinational glitch.
    assign dco_divider_field = s_q.div;
    assign dco_stage_field   = s_q.stage;
    assign div_effective     = s_q.div_eff;
    assign ring_length       = s_q.ring;
    assign regime            = s_q.reg_st;
    assign clock_stable_flag = s_q.stable;
endmodule // dco_loop_filter
`default_nettype wire

// file: verif/dco_loop_filter_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dco_loop_filter_properties (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       base_tick,
    input wire logic       internal_gen_enable,
    input wire logic       sw_stage_wr,
    input wire logic [7:0] sw_stage_data,
    input wire logic [7:0] dco_stage_field,
    input wire logic [3:0] dco_divider_field,
    input wire logic [3:0] div_effective,
    input wire logic [4:0] ring_length,
    input wire logic [1:0] regime,
    input wire logic       clock_stable_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Six cycles cover the enable synchroniser with one to spare.
    sequence s_off; !internal_gen_enable [*6]; endsequence
    sequence s_on; internal_gen_enable [*6]; endsequence
    chk_stage_write: assert property (
        s_off ##0 sw_stage_wr |=> dco_stage_field == $past(sw_stage_data))
        else $error("stage write lost");
    chk_write_ignored: assert property (
        s_on ##0 (sw_stage_wr && !base_tick) |=> $stable(dco_stage_field))
        else $error("stage written while enabled");
    chk_div_sat: assert property ($past(rst_n) |-> div_effective ==
        (($past(dco_divider_field) > 4'h9) ? 4'h9 : $past(dco_divider_field)))
        else $error("divider not saturated");
    chk_ring_len: assert property ($past(rst_n) |-> ring_length ==
        5'h11 + {1'b0, $past(dco_stage_field[7:5]), 1'b0})
        else $error("ring length wrong");
    chk_step_timing: assert property ($changed(dco_stage_field) |->
        $past(base_tick || sw_stage_wr)) else $error("stage moved off tick");
    chk_medium_step: assert property (
        $stable(regime) && regime == dco_pkg::REG_MEDIUM &&
        $changed(dco_stage_field) |-> (dco_stage_field -
        $past(dco_stage_field)) inside {8'h08, 8'hF8})
        else $error("medium step size wrong");
    chk_fine_step: assert property (
        $stable(regime) && regime == dco_pkg::REG_FINE &&
        $changed(dco_stage_field) |-> (dco_stage_field -
        $past(dco_stage_field)) inside {8'h01, 8'hFF})
        else $error("fine step size wrong");
    chk_stable_fine: assert property ($rose(clock_stable_flag) |->
        $past(base_tick) && regime == dco_pkg::REG_FINE)
        else $error("stable set outside fine entry");
    chk_stable_clear: assert property (s_off |=> !clock_stable_flag)
        else $error("stable while disabled");
endmodule // dco_loop_filter_properties
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       sys_clk, rst_n, base_tick, internal_gen_enable, mult_change;
    logic       err_valid, err_too_slow, sw_div_wr, sw_stage_wr;
    logic       clock_stable_flag;
    logic [9:0] err_pm;
    logic [3:0] sw_div_data, dco_divider_field, div_effective;
    logic [7:0] sw_stage_data, dco_stage_field;
    logic [4:0] ring_length;
    logic [1:0] regime;
    int         n_fail, samples_checked, cycles;
    dco_loop_filter i_dco_loop_filter (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Only every fourth base tick carries a correction.
    task automatic corr(input int n);
        repeat (4 * n) begin
            @(negedge sys_clk) base_tick = 1'b1;
            @(negedge sys_clk) base_tick = 1'b0;
        end
        @(negedge sys_clk);
    endtask
    task automatic strobe(input logic en);
        internal_gen_enable = en;
        repeat (8) @(negedge sys_clk);
        {sw_stage_wr, sw_div_wr} = 2'h3;
        @(negedge sys_clk) {sw_stage_wr, sw_div_wr} = 2'h0;
        @(negedge sys_clk);
    endtask
    task automatic t_writes;
        strobe(1'b0);
        chk(dco_stage_field, 8'h40);
        chk({4'h0, dco_divider_field}, 8'h0C);
        chk({4'h0, div_effective}, 8'h09);
        chk({3'h0, ring_length}, 8'h15);
        sw_stage_data = 8'h11;
        sw_div_data = 4'h3;
        strobe(1'b1);
        chk(dco_stage_field, 8'h40);
        chk({4'h0, dco_divider_field}, 8'h0C);
        $display("writes test done");
    endtask
    task automatic t_settle;
        corr(1);
        chk(dco_stage_field, 8'h48);
        chk({7'h0, clock_stable_flag}, 8'h00);
        corr(8);
        chk(dco_stage_field, 8'h81);
        chk({6'h0, regime}, {6'h0, dco_pkg::REG_FINE});
        chk({7'h0, clock_stable_flag}, 8'h01);
        err_pm = 10'h01E;
        corr(24);
        chk(dco_stage_field, 8'h98);
        chk({6'h0, regime}, {6'h0, dco_pkg::REG_DONE});
        mult_change = 1'b1;
        @(negedge sys_clk) mult_change = 1'b0;
        @(negedge sys_clk);
        chk({7'h0, clock_stable_flag}, 8'h00);
        chk({6'h0, regime}, {6'h0, dco_pkg::REG_COARSE});
        err_too_slow = 1'b1;
        err_pm = 10'h0C8;
        corr(1);
        chk(dco_stage_field, 8'h78);
        chk({6'h0, regime}, {6'h0, dco_pkg::REG_COARSE});
        $display("settle test done");
    endtask
    task automatic results;
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // The ceiling is about ten times the expected run length.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            $display("unexpected at %0t: run timed out", $time);
            results();
        end
    end
    initial begin
        {rst_n, base_tick, internal_gen_enable, mult_change} = 4'h0;
        {err_too_slow, sw_div_wr, sw_stage_wr} = 3'h0;
        err_valid = 1'b1;
        err_pm = 10'h064;
        sw_div_data = 4'hC;
        sw_stage_data = 8'h40;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        t_writes();
        t_settle();
        results();
    end
endmodule // tb
bind dco_loop_filter dco_loop_filter_properties i_props (.*);
`default_nettype wire
